// >>> rtl/ppmx_defs.vh
// Purpose: constants for the port pin mux controller
// Assumes: 8-bit ports, one clock
// Notes: definitions only
`ifndef PPMX_DEFS_VH
`define PPMX_DEFS_VH
`define PPMX_W 8
`define PPMX_ZERO 8'h00
`define PPMX_B_SCK 0
`define PPMX_B_TX 1
`define PPMX_B_RX 2
`define PPMX_B_TMR 3
`define PPMX_B_CPT 4
`define PPMX_C_IRQ0 6
`define PPMX_C_IRQ1 7
`define PPMX_EDGE_RISE 2'h1
`define PPMX_EDGE_FALL 2'h2
`define PPMX_EDGE_BOTH 2'h3
// clock cycles after reset before edge history is trusted
`define PPMX_WARM 3
`endif

// >>> rtl/ppmx_edge_det.v
// Purpose: selectable edge detector for one external interrupt input
// Assumes: input already synchronised
// Notes: 2'h0 disables detection
`include "ppmx_defs.vh"
module ppmx_edge_det
(
  // clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // control
  input wire i_enable,
  input wire [1:0] i_edge_sel,
  input wire i_level,
  // event
  output reg o_pulse
);
  reg prev_r;

  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      prev_r <= 1'b0;
      o_pulse <= 1'b0;
    end
    else
    begin
      prev_r <= i_level;
      case (i_edge_sel)
        `PPMX_EDGE_RISE: o_pulse <= i_enable & i_level & ~prev_r;
        `PPMX_EDGE_FALL: o_pulse <= i_enable & ~i_level & prev_r;
        `PPMX_EDGE_BOTH: o_pulse <= i_enable & (i_level ^ prev_r);
        default: o_pulse <= 1'b0;
      endcase
    end
  end
endmodule

// >>> rtl/ppmx_top.v
// Purpose: pin direction, pull-up and alternate function routing
// Assumes: configuration as plain ports, pins as in/out/oe triples
// Notes: pin inputs pass two flip-flops before use
`include "ppmx_defs.vh"
module ppmx_top
#(
  parameter W = `PPMX_W
)
(
  // clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // port a configuration
  input wire [W-1:0] i_port_a_direction_reg,
  input wire [W-1:0] i_port_a_pullup_reg,
  input wire [W-1:0] i_port_a_latch,
  // port b configuration
  input wire [W-1:0] i_port_b_direction_reg,
  input wire [W-1:0] i_port_b_ctrl_mode,
  input wire [W-1:0] i_port_b_latch,
  // port c configuration
  input wire [W-1:0] i_port_c_direction_reg,
  input wire [W-1:0] i_port_c_pullup_reg,
  input wire [W-1:0] i_port_c_ctrl_mode,
  input wire [W-1:0] i_port_c_latch,
  input wire [1:0] i_irq0_edge_sel,
  input wire [1:0] i_irq1_edge_sel,
  // pins
  input wire [W-1:0] i_port_a_pins,
  output wire [W-1:0] o_port_a_pins,
  output wire [W-1:0] o_port_a_pins_oe,
  output wire [W-1:0] o_port_a_pullup_en,
  input wire [W-1:0] i_port_b_pins,
  output wire [W-1:0] o_port_b_pins,
  output wire [W-1:0] o_port_b_pins_oe,
  input wire [W-1:0] i_port_c_pins,
  output wire [W-1:0] o_port_c_pins,
  output wire [W-1:0] o_port_c_pins_oe,
  output wire [W-1:0] o_port_c_pullup_en,
  // peripheral side
  input wire i_serial_clock_out,
  input wire i_serial_data_out,
  input wire i_timer_b_output,
  output reg o_serial_clock_pin,
  output reg o_async_clock_in,
  output reg o_serial_data_in,
  output reg o_async_receive_in,
  output reg o_capture_trigger_in,
  output reg [W-1:0] o_key_return_inputs,
  output wire o_ext_irq_0,
  output wire o_ext_irq_1,
  // port reads
  output reg [W-1:0] o_port_a_read,
  output reg [W-1:0] o_port_b_read,
  output reg [W-1:0] o_port_c_read
);
  // direction: 1 = input, as after reset
  reg [W-1:0] dir_a_r, dir_b_r, dir_c_r;
  reg [W-1:0] lat_a_r, lat_b_r, lat_c_r;
  reg [W-1:0] pu_a_r, pu_c_r, ctl_b_r, ctl_c_r;
  reg [W-1:0] sa1_r, sa2_r, sb1_r, sb2_r, sc1_r, sc2_r;
  reg [W-1:0] lat_b_nxt;
  wire [W-1:0] ones = {W{1'b1}};
  reg [W-1:0] rd_a_nxt, rd_b_nxt, rd_c_nxt;
  reg [W-1:0] kr_nxt;
  reg sck_nxt;
  reg rx_nxt;
  reg cpt_nxt;
  reg [`PPMX_WARM-1:0] warm_r;
  wire irq_ready;
  wire irq0_en;
  wire irq1_en;

  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      dir_a_r <= ones;
      dir_b_r <= ones;
      dir_c_r <= ones;
      lat_a_r <= `PPMX_ZERO;
      lat_b_r <= `PPMX_ZERO;
      lat_c_r <= `PPMX_ZERO;
      pu_a_r <= `PPMX_ZERO;
      pu_c_r <= `PPMX_ZERO;
      ctl_b_r <= `PPMX_ZERO;
      ctl_c_r <= `PPMX_ZERO;
      sa1_r <= `PPMX_ZERO;
      sa2_r <= `PPMX_ZERO;
      sb1_r <= `PPMX_ZERO;
      sb2_r <= `PPMX_ZERO;
      sc1_r <= `PPMX_ZERO;
      sc2_r <= `PPMX_ZERO;
    end
    else
    begin
      dir_a_r <= i_port_a_direction_reg;
      dir_b_r <= i_port_b_direction_reg;
      dir_c_r <= i_port_c_direction_reg;
      lat_a_r <= i_port_a_latch;
      lat_b_r <= lat_b_nxt;
      lat_c_r <= i_port_c_latch;
      pu_a_r <= i_port_a_pullup_reg;
      pu_c_r <= i_port_c_pullup_reg;
      ctl_b_r <= i_port_b_ctrl_mode;
      ctl_c_r <= i_port_c_ctrl_mode;
      sa1_r <= i_port_a_pins;
      sa2_r <= sa1_r;
      sb1_r <= i_port_b_pins;
      sb2_r <= sb1_r;
      sc1_r <= i_port_c_pins;
      sc2_r <= sc1_r;
    end
  end

  // serial and timer outputs replace the latch bit in control mode
  always @*
  begin
    lat_b_nxt = i_port_b_latch;
    if (i_port_b_ctrl_mode[`PPMX_B_SCK])
      lat_b_nxt[`PPMX_B_SCK] = i_serial_clock_out;
    if (i_port_b_ctrl_mode[`PPMX_B_TX])
      lat_b_nxt[`PPMX_B_TX] = i_serial_data_out;
    if (i_port_b_ctrl_mode[`PPMX_B_TMR])
      lat_b_nxt[`PPMX_B_TMR] = i_timer_b_output;
  end

  // enable from direction bit in every mode; data from latch, or peripheral output on port b control bits
  assign o_port_a_pins = lat_a_r;
  assign o_port_a_pins_oe = ~dir_a_r;
  assign o_port_a_pullup_en = dir_a_r & pu_a_r;
  assign o_port_b_pins = lat_b_r;
  assign o_port_b_pins_oe = ~dir_b_r;
  assign o_port_c_pins = lat_c_r;
  assign o_port_c_pins_oe = ~dir_c_r;
  assign o_port_c_pullup_en = dir_c_r & pu_c_r;

  // peripheral inputs see the pin only in control mode
  always @*
  begin
    sck_nxt = ctl_b_r[`PPMX_B_SCK] & sb2_r[`PPMX_B_SCK];
    rx_nxt = ctl_b_r[`PPMX_B_RX] & sb2_r[`PPMX_B_RX];
    cpt_nxt = ctl_b_r[`PPMX_B_CPT] & sb2_r[`PPMX_B_CPT];
    kr_nxt = ctl_c_r & sc2_r;
  end

  // port read: live pin for inputs, latch for outputs
  always @*
  begin
    rd_a_nxt = (dir_a_r & sa2_r) | (~dir_a_r & lat_a_r);
    rd_b_nxt = (dir_b_r & sb2_r) | (~dir_b_r & lat_b_r);
    rd_c_nxt = (dir_c_r & sc2_r) | (~dir_c_r & lat_c_r);
  end

  // routed inputs from synchronised pins
  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_serial_clock_pin <= 1'b0;
      o_async_clock_in <= 1'b0;
      o_serial_data_in <= 1'b0;
      o_async_receive_in <= 1'b0;
      o_capture_trigger_in <= 1'b0;
      o_key_return_inputs <= `PPMX_ZERO;
      o_port_a_read <= `PPMX_ZERO;
      o_port_b_read <= `PPMX_ZERO;
      o_port_c_read <= `PPMX_ZERO;
    end
    else
    begin
      o_serial_clock_pin <= sck_nxt;
      o_async_clock_in <= sck_nxt;
      o_serial_data_in <= rx_nxt;
      o_async_receive_in <= rx_nxt;
      o_capture_trigger_in <= cpt_nxt;
      o_key_return_inputs <= kr_nxt;
      o_port_a_read <= rd_a_nxt;
      o_port_b_read <= rd_b_nxt;
      o_port_c_read <= rd_c_nxt;
    end
  end

  // detectors held off until pin history is valid after reset
  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
      warm_r <= {`PPMX_WARM{1'b0}};
    else
      warm_r <= {warm_r[`PPMX_WARM-2:0], 1'b1};
  end

  assign irq_ready = warm_r[`PPMX_WARM-1];
  assign irq0_en = irq_ready & ctl_c_r[`PPMX_C_IRQ0];
  assign irq1_en = irq_ready & ctl_c_r[`PPMX_C_IRQ1];

  ppmx_edge_det u_irq0
  (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_enable(irq0_en),
    .i_edge_sel(i_irq0_edge_sel),
    .i_level(sc2_r[`PPMX_C_IRQ0]),
    .o_pulse(o_ext_irq_0)
  );

  ppmx_edge_det u_irq1
  (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_enable(irq1_en),
    .i_edge_sel(i_irq1_edge_sel),
    .i_level(sc2_r[`PPMX_C_IRQ1]),
    .o_pulse(o_ext_irq_1)
  );
endmodule

// >>> test/ppmx_pin_model.sv
// Purpose: board side of the pins
// Assumes: external drive unless floating
// Notes: floating pins without pull-up show the inverse of the latch
module ppmx_pin_model (
  input wire [23:0] i_oe, i_d, i_pu, i_x, i_fl,
  output wire [23:0] o_l
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_l = (i_oe & i_d) | (~i_oe & ~i_fl & i_x)
    | (~i_oe & i_fl & (i_pu | ~i_d));
endmodule

// >>> test/ppmx_top_properties.sv
// Purpose: port mux checker
// Assumes: one clock
// Notes: bound into ppmx_top
module ppmx_top_chk (
  input wire i_core_clk, i_rstn, o_capture_trigger_in, o_ext_irq_0,
  input wire [7:0] i_port_a_direction_reg, i_port_a_pullup_reg,
  input wire [7:0] i_port_b_direction_reg, i_port_b_ctrl_mode,
  input wire [7:0] i_port_c_ctrl_mode, o_key_return_inputs,
  input wire [7:0] o_port_a_pins_oe, o_port_b_pins_oe, o_port_a_pullup_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_oe_a; 1 |=> o_port_a_pins_oe == ~$past(i_port_a_direction_reg);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("oe a");
  property p_pu_a; 1 |=> o_port_a_pullup_en ==
    ($past(i_port_a_direction_reg) & $past(i_port_a_pullup_reg)); endproperty
  a_pu_a: assert property (p_pu_a) else $error("pu a");
  property p_oe_b; 1 |=> o_port_b_pins_oe == ~$past(i_port_b_direction_reg);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("oe b");
  property p_cap; !i_port_b_ctrl_mode[4] |-> ##2 !o_capture_trigger_in;
  endproperty
  a_cap: assert property (p_cap) else $error("cap");
  property p_sck; i_port_b_ctrl_mode[0] & !i_port_b_direction_reg[0]
    |=> o_port_b_pins_oe[0]; endproperty
  a_sck: assert property (p_sck) else $error("sck");
  property p_kr; 1 |=>
    !(o_key_return_inputs & ~$past(i_port_c_ctrl_mode, 2));
  endproperty
  a_kr: assert property (p_kr) else $error("kr");
  property p_irq; !i_port_c_ctrl_mode[6] [*5] |-> !o_ext_irq_0; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_rst; disable iff (1'b0) !i_rstn |=> !o_port_a_pins_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("rst");
  c_irq: cover property (o_ext_irq_0);
  c_cap: cover property (o_capture_trigger_in);
  c_kr: cover property (|o_key_return_inputs);
endmodule
bind ppmx_top ppmx_top_chk u_chk (.*);

// >>> test/ppmx_top_tb.sv
// Purpose: bench for ppmx_top
// Assumes: 25 MHz clock
// Notes: inputs change on the falling edge
module ppmx_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 0, i_rstn = 0, i_serial_clock_out = 1;
  logic i_serial_data_out = 0, i_timer_b_output = 1;
  logic [1:0] i_irq0_edge_sel = 0, i_irq1_edge_sel = 0;
  logic [7:0] i_port_a_direction_reg = 0, i_port_a_pullup_reg = 0;
  logic [7:0] i_port_a_latch = 0, i_port_b_direction_reg = 0;
  logic [7:0] i_port_b_ctrl_mode = 0, i_port_b_latch = 0, ext = 0, fl = 0;
  logic [7:0] i_port_c_direction_reg = 0, i_port_c_pullup_reg = 0;
  logic [7:0] i_port_c_ctrl_mode = 0, i_port_c_latch = 0;
  wire [7:0] i_port_a_pins, i_port_b_pins, i_port_c_pins, o_port_a_pins;
  wire [7:0] o_port_a_pins_oe, o_port_a_pullup_en, o_port_b_pins;
  wire [7:0] o_port_b_pins_oe, o_port_c_pins, o_port_c_pins_oe;
  wire [7:0] o_port_c_pullup_en, o_key_return_inputs, o_port_a_read;
  wire [7:0] o_port_b_read, o_port_c_read;
  wire o_serial_clock_pin, o_async_clock_in, o_serial_data_in;
  wire o_async_receive_in, o_capture_trigger_in, o_ext_irq_0, o_ext_irq_1;
  int fails = 0, cmp_count = 0;
  ppmx_top u_dut (.*);
  ppmx_pin_model u_pins (
    .i_oe({o_port_c_pins_oe, o_port_b_pins_oe, o_port_a_pins_oe}),
    .i_d({o_port_c_pins, o_port_b_pins, o_port_a_pins}),
    .i_pu({o_port_c_pullup_en, 8'h00, o_port_a_pullup_en}),
    .i_x({3{ext}}), .i_fl({16'h0000, fl}),
    .o_l({i_port_c_pins, i_port_b_pins, i_port_a_pins}));
  initial forever #20 i_core_clk = ~i_core_clk;
  initial
  begin
    #20000;
    fails++;
    close_out;
  end
  task chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task t_port_a;
    i_port_a_direction_reg = 8'h0f;
    i_port_a_pullup_reg = 8'h33;
    i_port_a_latch = 8'ha5;
    ext = 8'h0c;
    fl = 8'h03;
    tick(5);
    chk(o_port_a_pullup_en, 8'h03);
    chk(o_port_a_pins, 8'ha5);
    chk(o_port_a_read, 8'haf);
  endtask
  task t_port_b;
    i_port_b_direction_reg = 8'hf4;
    i_port_b_ctrl_mode = 8'h1f;
    ext = 8'h14;
    tick(5);
    chk(o_port_b_pins_oe, 8'h0b);
    chk(o_port_b_pins & 8'h0b, 8'h09);
    chk({3'h0, o_serial_clock_pin, o_async_clock_in, o_serial_data_in,
      o_async_receive_in, o_capture_trigger_in}, 8'h1f);
    i_port_b_ctrl_mode = 8'h00;
    i_port_b_latch = 8'h02;
    tick(5);
    chk(o_port_b_read, 8'h16);
    chk({7'h00, o_capture_trigger_in}, 8'h00);
  endtask
  task t_port_c;
    int n;
    i_port_c_direction_reg = 8'hff;
    i_port_c_pullup_reg = 8'h0f;
    i_port_c_ctrl_mode = 8'hc3;
    ext = 8'h00;
    tick(5);
    chk(o_port_c_pullup_en, 8'h0f);
    chk(o_port_c_pins_oe, 8'h00);
    for (int s = 1; s < 4; s++)
    begin
      i_irq0_edge_sel = s[1:0];
      i_irq1_edge_sel = s[1:0];
      for (int v = 1; v >= 0; v--)
      begin
        n = 0;
        ext = {v[0], v[0], 6'h3f};
        repeat (8)
        begin
          tick(1);
          n += o_ext_irq_0 + o_ext_irq_1;
        end
        chk(n[7:0], {6'h00, s[!v], 1'b0});
        chk(o_key_return_inputs, {v[0], v[0], 6'h03});
        chk(o_port_c_read, {v[0], v[0], 6'h3f});
      end
    end
  endtask
  initial
  begin
    tick(5);
    chk(o_port_a_pins_oe | o_port_b_pins_oe, 8'h00);
    chk(o_port_c_pins_oe, 8'h00);
    i_rstn = 1;
    tick(2);
    chk(o_port_a_pins_oe, 8'hff);
    t_port_a;
    t_port_b;
    t_port_c;
    close_out;
  end
endmodule
